/* File: design/mes_defs.svh */
// Register offsets, field positions and encodings of the motion event block
`ifndef MES_DEFS_SVH
`define MES_DEFS_SVH
// ==========================================
// Register offsets
`define MES_A_STATUS 8'h11
`define MES_A_PEAK0 8'h15
`define MES_A_PEAK1 8'h16
`define MES_A_PEAK2 8'h17
`define MES_A_PEAK3 8'h18
`define MES_A_PEAK4 8'h19
`define MES_A_PEAK5 8'h1A
`define MES_A_WTHR_X 8'h32
`define MES_A_WTHR_Y 8'h33
`define MES_A_WTHR_Z 8'h34
`define MES_A_QCTL 8'h3A
`define MES_A_MAP1 8'h3B
`define MES_A_MAP2 8'h3C
`define MES_A_LINK 8'h3E
`define MES_A_PWR 8'h3F
// ==========================================
// Power modes, power_control_reg [1:0]
`define MES_PM_STBY 2'h0
`define MES_PM_WAKE 2'h1
`define MES_PM_INST 2'h2
`define MES_PM_MEAS 2'h3
`define MES_PWR_BAND 2
// ==========================================
// Link modes, activity_link_mode [1:0], [2] autosleep, [3] referenced
`define MES_LK_DFLT 2'h0
`define MES_LK_LINK 2'h1
`define MES_LK_LOOP 2'h3
`define MES_LK_AUTO 2
`define MES_LK_REF 3
// ==========================================
// Queue control fields
`define MES_QC_STREAM 1
`define MES_QC_PEAK 3
`endif

/* File: design/mes_pkg.sv */
// Types shared by the motion event block
package mes_pkg;
   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
   } mes_axes_t;
   typedef struct packed {
      logic [1:0] pmode;
      logic band;
      logic [1:0] link;
      logic autosleep;
      logic act_ref;
      logic auto_on;
      logic awake;
      logic look_act;
      logic act_pend;
      logic inact_pend;
      logic warn_pend;
      logic [2:0] map1;
      logic [3:0] map2;
      logic [23:0] wthr;
      logic [7:0] qctl;
      mes_axes_t peak;
      logic [15:0] pmag;
      mes_axes_t shadow;
      logic in_impact;
      logic [1:0] shock_sync;
      logic [7:0] rdata;
      logic irq1;
      logic irq2;
      logic push;
   } mes_state_t;
endpackage

/* File: design/mes_top.sv */
// Motion event sequencer: linking, autosleep, awake, warning, peak hold
`timescale 1ns/1ps
`include "mes_defs.svh"
module mes_top
   import mes_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Samples and detectors
   input wire logic sample_valid,
   input wire mes_axes_t sample,
   input wire mes_axes_t ref_axes,
   input wire logic act_det,
   input wire logic inact_det,
   input wire logic shock_in,
   // Status and control outputs
   output logic irq_out_one,
   output logic irq_out_two,
   output logic shock_band_select,
   output logic [1:0] power_mode,
   output logic queue_peak_push,
   output mes_axes_t queue_peak_data
);
   mes_state_t s_reg;
   mes_state_t s_next;
   logic stat_rd;
   logic pk_rd;
   logic chain;
   logic linked;
   logic sensing;
   logic act_en;
   logic inact_en;
   logic act_ev;
   logic inact_ev;
   logic warn_hit;
   logic [15:0] mag;

   // ==========================================
   // Helpers
   function automatic logic [12:0] mes_abs(input logic [12:0] d);
      mes_abs = d[12] ? 13'(-d) : d;
   endfunction

   // Only the top 7 magnitude bits are squared; costs about 3 g of error
   function automatic logic [15:0] mes_sq7(input logic [11:0] v);
      logic [11:0] a;
      a = v[11] ? 12'(-v) : v;
      mes_sq7 = 16'(a[11:5] * a[11:5]);
   endfunction

   function automatic logic mes_over(input logic [11:0] v,
         input logic [11:0] r, input logic use_ref, input logic [7:0] t);
      logic [12:0] d;
      d = 13'({v[11], v}) - (use_ref ? 13'({r[11], r}) : 13'h0000);
      mes_over = mes_abs(d) > {1'b0, t, 4'h0};
   endfunction

   // ==========================================
   // Event qualification
   always_comb begin
      stat_rd = reg_rd && (reg_addr == `MES_A_STATUS);
      pk_rd = reg_rd && (reg_addr == `MES_A_PEAK0);
      chain = (s_reg.link != `MES_LK_DFLT) || s_reg.auto_on;
      linked = (s_reg.link == `MES_LK_LINK) && !s_reg.auto_on;
      sensing = (s_reg.pmode == `MES_PM_MEAS) ||
         (s_reg.pmode == `MES_PM_WAKE);
      if (chain) begin
         act_en = s_reg.look_act;
         inact_en = !s_reg.look_act;
         if (linked && (s_reg.act_pend || s_reg.inact_pend)) begin
            act_en = 1'b0;
            inact_en = 1'b0;
         end
      end else begin
         act_en = !s_reg.act_pend;
         inact_en = !s_reg.inact_pend;
      end
      act_ev = act_det && act_en && sensing;
      inact_ev = inact_det && inact_en && sensing;
      warn_hit = sample_valid && sensing &&
         (mes_over(sample.x, ref_axes.x, s_reg.act_ref,
            s_reg.wthr[23:16]) ||
         mes_over(sample.y, ref_axes.y, s_reg.act_ref, s_reg.wthr[15:8]) ||
         mes_over(sample.z, ref_axes.z, s_reg.act_ref, s_reg.wthr[7:0]));
      mag = mes_sq7(sample.x) + mes_sq7(sample.y) + mes_sq7(sample.z);
   end

   // ==========================================
   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.push = 1'b0;
      s_next.shock_sync = {s_reg.shock_sync[0], shock_in};
      if (reg_wr) begin
         unique case (reg_addr)
            `MES_A_PWR: begin
               s_next.pmode = reg_wdata[1:0];
               s_next.band = reg_wdata[`MES_PWR_BAND];
               s_next.auto_on = s_reg.autosleep &&
                  (reg_wdata[1:0] == `MES_PM_WAKE);
               if (s_next.auto_on) begin
                  s_next.look_act = 1'b1;
               end
            end
            `MES_A_LINK: begin
               s_next.link = reg_wdata[1:0];
               s_next.autosleep = reg_wdata[`MES_LK_AUTO];
               s_next.act_ref = reg_wdata[`MES_LK_REF];
               s_next.look_act = 1'b1;
               if (!reg_wdata[`MES_LK_AUTO]) begin
                  s_next.auto_on = 1'b0;
               end
            end
            `MES_A_WTHR_X: s_next.wthr[23:16] = reg_wdata;
            `MES_A_WTHR_Y: s_next.wthr[15:8] = reg_wdata;
            `MES_A_WTHR_Z: s_next.wthr[7:0] = reg_wdata;
            `MES_A_QCTL: s_next.qctl = reg_wdata;
            `MES_A_MAP1: s_next.map1 = reg_wdata[2:0];
            `MES_A_MAP2: s_next.map2 = reg_wdata[3:0];
            default: ;
         endcase
      end
      // Clear first so an event in the same cycle wins
      if (stat_rd) begin
         s_next.act_pend = 1'b0;
         s_next.inact_pend = 1'b0;
         s_next.warn_pend = 1'b0;
      end
      if (act_ev) begin
         s_next.act_pend = 1'b1;
         s_next.in_impact = 1'b1;
         if (chain) begin
            s_next.look_act = 1'b0;
            s_next.awake = 1'b1;
         end
         if (s_reg.pmode == `MES_PM_WAKE) begin
            s_next.pmode = `MES_PM_MEAS;
         end
      end
      if (inact_ev) begin
         s_next.inact_pend = 1'b1;
         s_next.in_impact = 1'b0;
         if (chain) begin
            s_next.look_act = 1'b1;
            s_next.awake = 1'b0;
         end
         if (s_reg.auto_on) begin
            s_next.pmode = `MES_PM_WAKE;
         end
         s_next.push = s_reg.in_impact && s_reg.qctl[`MES_QC_PEAK] &&
            s_reg.qctl[`MES_QC_STREAM];
      end
      if ((s_reg.pmode == `MES_PM_INST) && s_reg.shock_sync[1]) begin
         s_next.pmode = `MES_PM_MEAS;
      end
      // Next-cycle mode, so a mode write never leaves awake stale
      if ((s_next.link == `MES_LK_DFLT) || s_next.auto_on) begin
         s_next.awake = (s_next.pmode == `MES_PM_MEAS);
      end
      if (warn_hit) begin
         s_next.warn_pend = 1'b1;
      end
      // Whole set moves at once, so a burst read never mixes samples
      if (pk_rd) begin
         s_next.shadow = s_reg.peak;
         s_next.peak = '0;
         s_next.pmag = 16'h0000;
      end
      if (sample_valid && s_reg.in_impact && s_reg.qctl[`MES_QC_PEAK] &&
            (mag > s_next.pmag)) begin
         s_next.peak = sample;
         s_next.pmag = mag;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `MES_A_STATUS: s_next.rdata = {4'h0, s_reg.warn_pend,
               s_reg.inact_pend, s_reg.act_pend, s_reg.awake};
            `MES_A_PEAK0: s_next.rdata = s_reg.peak.x[11:4];
            `MES_A_PEAK1: s_next.rdata = {s_reg.shadow.x[3:0], 4'h0};
            `MES_A_PEAK2: s_next.rdata = s_reg.shadow.y[11:4];
            `MES_A_PEAK3: s_next.rdata = {s_reg.shadow.y[3:0], 4'h0};
            `MES_A_PEAK4: s_next.rdata = s_reg.shadow.z[11:4];
            `MES_A_PEAK5: s_next.rdata = {s_reg.shadow.z[3:0], 4'h0};
            `MES_A_WTHR_X: s_next.rdata = s_reg.wthr[23:16];
            `MES_A_WTHR_Y: s_next.rdata = s_reg.wthr[15:8];
            `MES_A_WTHR_Z: s_next.rdata = s_reg.wthr[7:0];
            `MES_A_QCTL: s_next.rdata = s_reg.qctl;
            `MES_A_MAP1: s_next.rdata = {5'h00, s_reg.map1};
            `MES_A_MAP2: s_next.rdata = {4'h0, s_reg.map2};
            `MES_A_LINK: s_next.rdata = {4'h0, s_reg.act_ref,
               s_reg.autosleep, s_reg.link};
            `MES_A_PWR: s_next.rdata = {5'h00, s_reg.band, s_reg.pmode};
            default: s_next.rdata = 8'h00;
         endcase
      end
      // Warning bit exists only in the second map
      s_next.irq1 = |(s_next.map1 & {s_next.inact_pend,
         s_next.act_pend, s_next.awake});
      s_next.irq2 = |(s_next.map2 & {s_next.warn_pend, s_next.inact_pend,
         s_next.act_pend, s_next.awake});
   end

   // ==========================================
   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign irq_out_one = s_reg.irq1;
   assign irq_out_two = s_reg.irq2;
   assign shock_band_select = s_reg.band;
   assign power_mode = s_reg.pmode;
   assign queue_peak_push = s_reg.push;
   assign queue_peak_data = s_reg.peak;

   // ==========================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_auto_act;
      s_reg.auto_on && act_ev && !reg_wr;
   endsequence
   sequence s_auto_inact;
      s_reg.auto_on && inact_ev && !reg_wr;
   endsequence
   sequence s_shock;
      (s_reg.pmode == `MES_PM_INST) ##0 s_reg.shock_sync[1] ##0 !reg_wr;
   endsequence

   a_linked_wait: assert property (linked && s_reg.act_pend &&
      !stat_rd && !reg_wr |=> !$rose(s_reg.inact_pend))
      else $error("linked mode armed before service");
   a_alt_look: assert property (chain && act_ev && !reg_wr |=>
      !s_reg.look_act ##0 !act_en)
      else $error("activity search not dropped");
   a_auto_meas: assert property (s_auto_act |=>
      (s_reg.pmode == `MES_PM_MEAS) && !s_reg.look_act)
      else $error("autosleep activity did not measure");
   a_auto_wake: assert property (s_auto_inact |=>
      s_reg.pmode == `MES_PM_WAKE)
      else $error("autosleep inactivity did not sleep");
   a_meas_hold: assert property (!s_reg.auto_on &&
      s_reg.pmode == `MES_PM_MEAS && !reg_wr |=> s_reg.pmode == `MES_PM_MEAS)
      else $error("measurement left without host");
   a_awake_meas: assert property (s_reg.link == `MES_LK_DFLT &&
      !s_reg.auto_on |-> s_reg.awake == (s_reg.pmode == `MES_PM_MEAS))
      else $error("awake differs from measurement");
   a_inst_wake: assert property (s_shock |=>
      s_reg.pmode == `MES_PM_MEAS ##1
      (s_reg.pmode == `MES_PM_MEAS || $past(reg_wr)))
      else $error("shock did not start measurement");
   // Warning flag must never leak in, whatever else is mapped
   a_irq1_warn: assert property (!(|(s_reg.map1 & {s_reg.inact_pend,
      s_reg.act_pend, s_reg.awake})) |-> !irq_out_one)
      else $error("warning reached first output");
   a_link_sleep: assert property (chain && !s_reg.auto_on &&
      inact_ev && !reg_wr |=> !s_reg.awake)
      else $error("inactivity left awake set");
   a_peak_clear: assert property (pk_rd && !sample_valid |=>
      s_reg.pmag == 16'h0000 && s_reg.peak == '0)
      else $error("peak read did not clear");
   a_peak_mono: assert property (!pk_rd |=>
      s_reg.pmag >= $past(s_reg.pmag))
      else $error("stored peak decreased");
endmodule // mes_top

/* File: test/mes_host.sv */
// Host processor model on the register port of the motion event block
`timescale 1ns/1ps
`include "mes_defs.svh"
module mes_host (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // ==========
   // Single accesses, strobe held for one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // ==========
   // Peak setup and burst read
   task automatic peak_setup(input logic [7:0] qc);
      wr(`MES_A_QCTL, qc);
      wr(`MES_A_LINK, 8'h03);
   endtask
   // Back to back so all three axes come from one snapshot
   task automatic burst(output logic [47:0] d);
      @(negedge clk);
      reg_rd = 1'b1;
      for (int i = 0; i < 6; i++) begin
         reg_addr = `MES_A_PEAK0 + 8'(i);
         @(negedge clk);
         d[47 - 8 * i -: 8] = reg_rdata;
      end
      reg_rd = 1'b0;
   endtask
endmodule // mes_host

/* File: test/mes_top_tb.sv */
// Self-checking bench of the motion event sequencer
`timescale 1ns/1ps
`include "mes_defs.svh"
`define CK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module mes_top_tb
   import mes_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic reg_wr, reg_rd, irq1, irq2, band, push;
   logic sample_valid = 1'b0;
   logic act_det = 1'b0;
   logic inact_det = 1'b0;
   logic shock_in = 1'b0;
   logic [1:0] pm;
   mes_axes_t sample = '0;
   mes_axes_t ref_axes = '0;
   mes_axes_t qdata, last_q;
   logic [47:0] pk;
   int bad_count = 0;
   int num_checks = 0;
   int pushes = 0;
   localparam logic [23:0] ROWS [7] = '{
      {`MES_A_MAP1, 8'h05, 8'h05}, {`MES_A_MAP2, 8'h0A, 8'h0A},
      {`MES_A_WTHR_X, 8'h12, 8'h12}, {`MES_A_WTHR_Z, 8'h7E, 8'h7E},
      {`MES_A_QCTL, 8'h38, 8'h38}, {`MES_A_LINK, 8'h0B, 8'h0B},
      {8'h50, 8'h5A, 8'h00}};
   always #2.5 clk = ~clk;
   always @(posedge clk) if (push) begin
      pushes++;
      last_q = qdata;
   end
   mes_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample(sample),
      .ref_axes(ref_axes), .act_det(act_det), .inact_det(inact_det),
      .shock_in(shock_in), .irq_out_one(irq1), .irq_out_two(irq2),
      .shock_band_select(band), .power_mode(pm), .queue_peak_push(push),
      .queue_peak_data(qdata));
   mes_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // ==========
   // Stimulus helpers
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic ev(input logic a);
      @(negedge clk);
      act_det = a;
      inact_det = ~a;
      @(negedge clk);
      act_det = 1'b0;
      inact_det = 1'b0;
      tick(2);
   endtask
   task automatic smp(input logic [11:0] x, input logic [11:0] y);
      @(negedge clk);
      sample = '{x, y, 12'h000};
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
      sample = ~sample;
   endtask
   task automatic impact(input logic [11:0] x, input logic [11:0] y);
      ev(1'b1);
      smp(x >> 1, 12'h000);
      smp(x, y);
      smp(12'h080, 12'h000);
      ev(1'b0);
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   // ==========
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      `CK("pm_rst", 2'h0, pm)
      `CK("irq_rst", 2'h0, {irq1, irq2})
      @(negedge clk);
      rst_b = 1'b1;
      foreach (ROWS[i]) begin
         u_host.wr(ROWS[i][23:16], ROWS[i][15:8]);
         u_host.rd(ROWS[i][23:16], rd);
         `CK("reg", ROWS[i][7:0], rd)
      end
      // Autosleep entered from wake-up
      u_host.wr(`MES_A_MAP1, 8'h01);
      u_host.wr(`MES_A_LINK, 8'h04);
      u_host.wr(`MES_A_PWR, 8'h01);
      tick(1);
      `CK("pm_wake", 2'h1, pm)
      ev(1'b1);
      `CK("pm_act", 2'h3, pm)
      `CK("awake_hi", 1'b1, irq1)
      ev(1'b0);
      `CK("pm_inact", 2'h1, pm)
      `CK("awake_lo", 1'b0, irq1)
      // Measurement chosen by hand never drops back
      u_host.wr(`MES_A_PWR, 8'h00);
      u_host.wr(`MES_A_PWR, 8'h03);
      // Flags cleared first, else both events would be refused
      u_host.rd(`MES_A_STATUS, rd);
      ev(1'b1);
      ev(1'b0);
      `CK("pm_manual", 2'h3, pm)
      // Linked, then loop
      u_host.wr(`MES_A_LINK, 8'h01);
      u_host.rd(`MES_A_STATUS, rd);
      ev(1'b1);
      ev(1'b0);
      `CK("linked_wait", 1'b1, irq1)
      u_host.rd(`MES_A_STATUS, rd);
      `CK("status", 8'h03, rd)
      ev(1'b1);
      u_host.rd(`MES_A_STATUS, rd);
      `CK("act_masked", 8'h01, rd)
      ev(1'b0);
      `CK("linked_sleep", 1'b0, irq1)
      u_host.wr(`MES_A_LINK, 8'h03);
      ev(1'b1);
      `CK("loop_act", 1'b1, irq1)
      ev(1'b0);
      `CK("loop_free", 1'b0, irq1)
      // Warning on one sample, second output only
      u_host.rd(`MES_A_STATUS, rd);
      u_host.wr(`MES_A_LINK, 8'h00);
      u_host.wr(`MES_A_MAP1, 8'h06);
      u_host.wr(`MES_A_MAP2, 8'h08);
      u_host.wr(`MES_A_WTHR_X, 8'h02);
      smp(12'h040, 12'h000);
      tick(2);
      `CK("warn_irq", 2'b01, {irq1, irq2})
      `CK("warn_pm", 2'h3, pm)
      // Referenced compare: same sample at the reference gives no warning
      u_host.rd(`MES_A_STATUS, rd);
      u_host.wr(`MES_A_LINK, 8'h08);
      ref_axes.x = 12'h040;
      smp(12'h040, 12'h000);
      tick(2);
      `CK("warn_ref", 2'b00, {irq1, irq2})
      // Peak capture over two impacts, second one lower
      u_host.rd(`MES_A_STATUS, rd);
      u_host.peak_setup(8'h3A);
      pushes = 0;
      impact(12'h300, 12'h100);
      `CK("push_x", 12'h300, last_q.x)
      impact(12'h200, 12'h000);
      `CK("pushes", 2, pushes)
      u_host.burst(pk);
      `CK("peak", 48'h300010000000, pk)
      u_host.rd(`MES_A_PEAK0, rd);
      `CK("peak_clr", 8'h00, rd)
      // Instant-on wake by shock
      u_host.wr(`MES_A_PWR, 8'h06);
      tick(1);
      `CK("inst", 3'h6, {band, pm})
      shock_in = 1'b1;
      for (int n = 0; n < 10 && pm !== 2'h3; n++) tick(1);
      `CK("shock", 2'h3, pm)
      shock_in = 1'b0;
      tick(20);
      `CK("stay", 2'h3, pm)
      tally_and_finish();
   end
endmodule // mes_top_tb
